// *** logic/sram_ctrl_defines.svh ***
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH
`define CLK_PERIOD_PS        4000
`define WRITE_DATA_SETUP_PS  7000
`define ADDR_SETUP_TO_END_PS 10000
`define LANE_TO_END_PS       10000
`define LANE_TO_VALID_PS     6000
`define LANE_TO_FLOAT_PS     6000
`define DESELECT_STANDBY_PS  12000
`define CYCLE_TIME_PS        12000
`define CEIL_CYC(t)          (((t) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// *** logic/sram_ctrl_pkg.sv ***
package sram_ctrl_pkg;
    typedef enum logic [2:0] {
        st_idle,
        st_setup,
        st_strobe,
        st_read,
        st_release,
        st_recover
    } state_type;
endpackage : sram_ctrl_pkg

// *** logic/sram_host_ctrl.sv ***
`timescale 1ns/1ps
`include "sram_ctrl_defines.svh"
module sram_host_ctrl #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_lanes,
    input  wire logic              retention_req,
    output logic                   retention_ok,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   chip_select_n,
    output logic                   write_strobe_n,
    output logic                   output_enable_n,
    output logic                   lower_lane_select_n,
    output logic                   upper_lane_select_n,
    output logic [ADDR_W-1:0]      addr_pins,
    output logic [DATA_W-1:0]      data_pins_out,
    output logic                   data_pins_oe,
    input  wire logic [DATA_W-1:0] data_pins_in
);
    localparam int WR_CYC  = `CEIL_CYC(`ADDR_SETUP_TO_END_PS);
    localparam int SD_CYC  = `CEIL_CYC(`WRITE_DATA_SETUP_PS);
    localparam int BW_CYC  = `CEIL_CYC(`LANE_TO_END_PS);
    localparam int STB_CYC = (WR_CYC > BW_CYC) ? ((WR_CYC > SD_CYC) ? WR_CYC : SD_CYC)
                                               : ((BW_CYC > SD_CYC) ? BW_CYC : SD_CYC);
    // four extra cycles cover the three input flops and the agreement filter
    localparam int RD_CYC  = `CEIL_CYC(`LANE_TO_VALID_PS) + 4;
    localparam int FL_CYC  = `CEIL_CYC(`LANE_TO_FLOAT_PS);
    localparam int PD_CYC  = `CEIL_CYC(`DESELECT_STANDBY_PS);
    localparam int REC_CYC = `CEIL_CYC(`CYCLE_TIME_PS);
    localparam int CNT_W   = 4;

    if (ADDR_W != 16 || DATA_W != 16) begin : g_bad_size
        $error("sram_host_ctrl: 64K x 16 only");
    end
    if (RD_CYC >= 16 || STB_CYC >= 16) begin : g_bad_count
        $error("sram_host_ctrl: counter too narrow");
    end
    if (PD_CYC >= 16 || FL_CYC >= 16 || REC_CYC >= 16) begin : g_bad_wait
        $error("sram_host_ctrl: wait counter too narrow");
    end

    sram_ctrl_pkg::state_type state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              cs_q, cs_d, we_q, we_d, oe_q, oe_d, drv_q, drv_d;
    logic [1:0]        lane_q, lane_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic              rsp_q, rsp_d, ret_q, ret_d;
    logic [CNT_W-1:0]  pd_q, pd_d;
    logic [DATA_W-1:0] sync1_q, sync2_q, sync3_q;
    logic [DATA_W-1:0] sync1_d, sync2_d, sync3_d;
    logic [DATA_W-1:0] pin_q, pin_d;

    // a new pin value counts once the last two flops agree
    always_comb begin
        sync1_d = data_pins_in;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        pin_d   = pin_q;
        if (sync2_q == sync3_q) begin
            pin_d = sync3_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
            sync3_q <= 16'h0000;
            pin_q   <= 16'h0000;
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            pin_q   <= pin_d;
        end
    end

    assign req_ready = (state_q == sram_ctrl_pkg::st_idle) && !retention_req;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cs_d    = cs_q;
        we_d    = we_q;
        oe_d    = oe_q;
        drv_d   = drv_q;
        lane_d  = lane_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        rdat_d  = rdat_q;
        rsp_d   = 1'b0;
        pd_d    = pd_q;
        ret_d   = ret_q;
        if (cs_q) begin
            pd_d = 4'h0;
        end else if (pd_q != PD_CYC[CNT_W-1:0]) begin
            pd_d = pd_q + 4'h1;
        end
        unique case (state_q)
            sram_ctrl_pkg::st_idle: begin
                ret_d = retention_req && !cs_q && pd_q == PD_CYC[CNT_W-1:0];
                if (req_valid && req_ready) begin
                    // address and lanes settle a cycle before select falls on writes; reads assert select on the same edge
                    addr_d  = req_addr;
                    lane_d  = req_lanes;
                    wdat_d  = req_wdata;
                    we_d    = 1'b0;
                    oe_d    = 1'b0;
                    cnt_d   = 4'h0;
                    ret_d   = 1'b0;
                    state_d = req_write ? sram_ctrl_pkg::st_setup : sram_ctrl_pkg::st_read;
                    cs_d    = !req_write;
                    oe_d    = !req_write;
                    drv_d   = req_write;
                end
            end
            sram_ctrl_pkg::st_setup: begin
                cs_d    = 1'b1;
                we_d    = 1'b1;
                state_d = sram_ctrl_pkg::st_strobe;
            end
            sram_ctrl_pkg::st_strobe: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(STB_CYC - 1)) begin
                    // strobe alone ends the write; data and address held one more cycle
                    we_d    = 1'b0;
                    cnt_d   = 4'h0;
                    state_d = sram_ctrl_pkg::st_release;
                end
            end
            sram_ctrl_pkg::st_read: begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(RD_CYC - 1)) begin
                    rdat_d = {lane_q[1] ? pin_q[15:8] : 8'h00,
                              lane_q[0] ? pin_q[7:0] : 8'h00};
                    rsp_d   = 1'b1;
                    oe_d    = 1'b0;
                    cs_d    = 1'b0;
                    lane_d  = 2'b00;
                    cnt_d   = 4'h0;
                    state_d = sram_ctrl_pkg::st_recover;
                end
            end
            sram_ctrl_pkg::st_release: begin
                cs_d    = 1'b0;
                drv_d   = 1'b0;
                lane_d  = 2'b00;
                rsp_d   = 1'b1;
                state_d = sram_ctrl_pkg::st_recover;
            end
            sram_ctrl_pkg::st_recover: begin
                // lane float and cycle time before the next access
                cnt_d = cnt_q + 4'h1;
                if (cnt_q >= 4'(((FL_CYC > REC_CYC) ? FL_CYC : REC_CYC) - 1)) begin
                    cnt_d   = 4'h0;
                    state_d = sram_ctrl_pkg::st_idle;
                end
            end
            default: begin
                // unused state code: deselect and go back to idle
                cs_d    = 1'b0;
                we_d    = 1'b0;
                oe_d    = 1'b0;
                drv_d   = 1'b0;
                lane_d  = 2'b00;
                cnt_d   = 4'h0;
                state_d = sram_ctrl_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sram_ctrl_pkg::st_idle;
            cnt_q   <= 4'h0;
            cs_q    <= 1'b0;
            we_q    <= 1'b0;
            oe_q    <= 1'b0;
            drv_q   <= 1'b0;
            lane_q  <= 2'b00;
            addr_q  <= 16'h0000;
            wdat_q  <= 16'h0000;
            rdat_q  <= 16'h0000;
            rsp_q   <= 1'b0;
            pd_q    <= 4'h0;
            ret_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cs_q    <= cs_d;
            we_q    <= we_d;
            oe_q    <= oe_d;
            drv_q   <= drv_d;
            lane_q  <= lane_d;
            addr_q  <= addr_d;
            wdat_q  <= wdat_d;
            rdat_q  <= rdat_d;
            rsp_q   <= rsp_d;
            pd_q    <= pd_d;
            ret_q   <= ret_d;
        end
    end

    // internal flags are active high; pins are active low
    assign chip_select_n       = !cs_q;
    assign write_strobe_n      = !we_q;
    assign output_enable_n     = !oe_q;
    assign lower_lane_select_n = !lane_q[0];
    assign upper_lane_select_n = !lane_q[1];
    assign addr_pins           = addr_q;
    assign data_pins_out       = wdat_q;
    assign data_pins_oe        = drv_q;
    assign rsp_valid           = rsp_q;
    assign rsp_rdata           = rdat_q;
    assign retention_ok        = ret_q;
endmodule : sram_host_ctrl

// *** verification/sram_host_ctrl_asserts.sv ***
`timescale 1ns/1ps
module sram_host_ctrl_asserts #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire logic              req_write,
    input wire logic              retention_ok,
    input wire logic              rsp_valid,
    input wire logic              chip_select_n,
    input wire logic              write_strobe_n,
    input wire logic              output_enable_n,
    input wire logic              lower_lane_select_n,
    input wire logic              upper_lane_select_n,
    input wire logic [ADDR_W-1:0] addr_pins,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic              data_pins_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence strobe_pulse;
        !write_strobe_n[*2] ##1 write_strobe_n;
    endsequence
    a_write_selected: assert property ($fell(write_strobe_n) |-> !chip_select_n)
        else $error("strobe low without select");
    a_strobe_width: assert property ($fell(write_strobe_n) |=> strobe_pulse)
        else $error("strobe width wrong");
    a_data_stable: assert property (!write_strobe_n |-> $stable(data_pins_out) && data_pins_oe)
        else $error("write data moved");
    a_addr_stable: assert property (!write_strobe_n |-> $stable(addr_pins))
        else $error("address moved in write");
    a_lanes_held: assert property (!write_strobe_n |-> $stable(lower_lane_select_n)
        && $stable(upper_lane_select_n))
        else $error("lane enables moved in write");
    a_end_order: assert property ($rose(write_strobe_n) |-> !chip_select_n ##1 chip_select_n)
        else $error("write end order wrong");
    a_read_float: assert property (!output_enable_n |-> !data_pins_oe && write_strobe_n)
        else $error("host drives during read");
    a_write_latency: assert property (req_valid && req_ready && req_write |-> ##6 rsp_valid)
        else $error("write answer late");
    a_read_latency: assert property (req_valid && req_ready && !req_write |-> ##7 rsp_valid)
        else $error("read answer late");
    a_recover_gap: assert property (rsp_valid |=> !req_ready [*2])
        else $error("access too soon");
    a_retention_safe: assert property (retention_ok |-> chip_select_n)
        else $error("retention while selected");
endmodule : sram_host_ctrl_asserts
bind sram_host_ctrl sram_host_ctrl_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (.*);

// *** verification/sram_device_model.sv ***
`timescale 1ns/1ps
module sram_device_model (
    input wire logic        chip_select_n,
    input wire logic        write_strobe_n,
    input wire logic        output_enable_n,
    input wire logic        lower_lane_select_n,
    input wire logic        upper_lane_select_n,
    input wire logic [15:0] addr_pins,
    input wire logic [15:0] data_pins,
    output logic     [15:0] q
);
    logic [15:0] mem [0:65535];
    logic [15:0] nxt;
    wire         rd = !chip_select_n && !output_enable_n && write_strobe_n;
    wire         standby_n;
    assign #12 standby_n = !chip_select_n;
    always @* begin
        if (!chip_select_n && !write_strobe_n) begin
            if (!lower_lane_select_n) mem[addr_pins][7:0] = data_pins[7:0];
            if (!upper_lane_select_n) mem[addr_pins][15:8] = data_pins[15:8];
        end
    end
    // floating lanes show inverted data, never a stale copy
    always @* begin
        nxt[7:0]  = (rd && !lower_lane_select_n) ? mem[addr_pins][7:0] : ~mem[addr_pins][7:0];
        nxt[15:8] = (rd && !upper_lane_select_n) ? mem[addr_pins][15:8] : ~mem[addr_pins][15:8];
    end
    assign #6 q = nxt;
endmodule : sram_device_model

// *** verification/async_sram_byte_lane_access_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module async_sram_byte_lane_access_tb_top;
    logic mclk, rst_n, req_valid, req_ready, req_write, retention_req, retention_ok;
    logic rsp_valid, cs_n, we_n, oe_n, lo_n, hi_n, data_pins_oe;
    logic [15:0] req_addr, req_wdata, rsp_rdata, addr_pins, data_pins_out, q;
    logic [1:0]  req_lanes;
    int          errors = 0;
    int          samples_checked = 0;
    wire  [15:0] data_pins_in = data_pins_oe ? data_pins_out : q;
    // released host pins show the inverse, never a stale copy
    wire  [15:0] host_pins    = data_pins_oe ? data_pins_out : ~data_pins_out;
    sram_host_ctrl i_dut (.mclk, .rst_n, .req_valid, .req_ready, .req_write, .req_addr,
        .req_wdata, .req_lanes, .retention_req, .retention_ok, .rsp_valid, .rsp_rdata,
        .chip_select_n(cs_n), .write_strobe_n(we_n), .output_enable_n(oe_n),
        .lower_lane_select_n(lo_n), .upper_lane_select_n(hi_n), .addr_pins,
        .data_pins_out, .data_pins_oe, .data_pins_in);
    sram_device_model i_mem (.chip_select_n(cs_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .lower_lane_select_n(lo_n), .upper_lane_select_n(hi_n),
        .addr_pins, .data_pins(host_pins), .q);
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          input logic [1:0] l, output logic [15:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr  <= a;
        req_wdata <= d;
        req_lanes <= l;
        do @(negedge mclk); while (req_ready !== 1'b1 && ++n < 40);
        @(posedge mclk);
        req_valid <= 1'b0;
        do @(negedge mclk); while (rsp_valid !== 1'b1 && ++n < 80);
        if (n >= 80) begin
            errors++;
            $display("CHECK FAILED %0t no answer", $time);
        end
        r = rsp_rdata;
    endtask : access
    task automatic test_full;
        logic [15:0] r;
        access(1'b1, 16'h0001, 16'ha55a, 2'h3, r);
        access(1'b1, 16'hffff, 16'h0f0f, 2'h3, r);
        access(1'b0, 16'h0001, 16'h0000, 2'h3, r);
        `CHK(r, 16'ha55a)
        access(1'b0, 16'hffff, 16'h0000, 2'h3, r);
        `CHK(r, 16'h0f0f)
        $display("test full done");
    endtask : test_full
    task automatic test_lanes;
        logic [15:0] r;
        access(1'b1, 16'h0001, 16'h1234, 2'h1, r);
        access(1'b1, 16'h0001, 16'hc3ff, 2'h2, r);
        access(1'b0, 16'h0001, 16'h0000, 2'h3, r);
        `CHK(r, 16'hc334)
        access(1'b0, 16'h0001, 16'h0000, 2'h2, r);
        `CHK(r, 16'hc300)
        access(1'b0, 16'h0001, 16'h0000, 2'h1, r);
        `CHK(r, 16'h0034)
        $display("test lanes done");
    endtask : test_lanes
    task automatic test_noop;
        logic [15:0] r;
        access(1'b1, 16'h0001, 16'hffff, 2'h0, r);
        access(1'b0, 16'h0001, 16'h0000, 2'h3, r);
        `CHK(r, 16'hc334)
        $display("test noop done");
    endtask : test_noop
    task automatic test_retention;
        logic [15:0] r;
        int n;
        @(posedge mclk);
        retention_req <= 1'b1;
        for (n = 0; n < 30 && retention_ok !== 1'b1; n++) @(negedge mclk);
        `CHK(retention_ok, 1'b1)
        `CHK(cs_n, 1'b1)
        `CHK(i_mem.standby_n, 1'b0)
        `CHK(req_ready, 1'b0)
        @(posedge mclk);
        retention_req <= 1'b0;
        access(1'b0, 16'hffff, 16'h0000, 2'h3, r);
        `CHK(r, 16'h0f0f)
        $display("test retention done");
    endtask : test_retention
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #20000;
        errors++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        {rst_n, req_valid, req_write, retention_req, req_lanes} = '0;
        {req_addr, req_wdata} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        test_full();
        test_lanes();
        test_noop();
        test_retention();
        complete_run();
    end
endmodule : async_sram_byte_lane_access_tb_top
